// ==== dma_channel_pkg.sv ====
// constants and types shared by the dual dma controller address/count block
package dma_channel_pkg;

  // ==========================================================================
  // io decode: upper twelve bits of the io address select a range
  localparam logic [11:0] PRI_IO_BASE  = 12'h000;
  localparam logic [11:0] SEC_IO_BASE  = 12'h00C;
  localparam logic [11:0] PAGE_IO_BASE = 12'h008;

  // ==========================================================================
  // register index within a controller range
  localparam logic [3:0] REG_STATUS_CMD = 4'h8;
  localparam logic [3:0] REG_MASK_ONE   = 4'hA;
  localparam logic [3:0] REG_MODE       = 4'hB;
  localparam logic [3:0] REG_FF_CTRL    = 4'hC;
  localparam logic [3:0] REG_MASTER_CLR = 4'hD;

  // ==========================================================================
  // field positions
  localparam int CMD_ADDR_HOLD_BIT = 1;
  localparam int MASK_SET_BIT      = 2;
  localparam int MODE_AUTOINIT_BIT = 4;
  localparam int MODE_DECR_BIT     = 5;
  localparam int FF_CTRL_BIT       = 0;

  // ==========================================================================
  // reset values and fixed values
  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam logic [7:0]  PAGE_RESET   = 8'h00;
  localparam logic [7:0]  CMD_RESET    = 8'h00;
  localparam logic [7:0]  MASK_RESET   = 8'hFF;
  localparam logic        FF_RESET     = 1'b0;
  localparam logic [15:0] COUNT_LAST   = 16'h0000;
  localparam logic [15:0] WORD_STEP    = 16'h0001;
  localparam logic [2:0]  CASCADE_CHAN = 3'h4;
  localparam int          CHANS        = 8;

  typedef enum {XFER_IDLE, XFER_ACTIVE} xfer_state_t;

endpackage : dma_channel_pkg

// ==== dma_channel_address_count.sv ====
// dual cascaded dma controller: address/count registers, byte pointer, transfer engine
// ============================================================================
// fifo between transfer engine and memory side
module dma_word_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  wire              full  = (wr_ptr_q ^ rd_ptr_q) == {1'b1, {AW{1'b0}}};
  wire              empty = (wr_ptr_q == rd_ptr_q);
  wire              push  = in_valid && !full;
  wire              pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = store_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (push) store_q[wr_ptr_q[AW-1:0]] <= in_data;
  end
endmodule : dma_word_fifo

// ============================================================================
// Summary of operation
// [R1] two four-channel controllers, byte and word
// [R2] secondary channel zero only cascades, never transfers
// [R3] requests 0-3 primary, 5-7 secondary
// [R4] decode 000-00F and 0C0-0CF
// [R5] page registers decoded at 080-087, 088-08F read zero
// [R6] byte-wide registers, wide values by successive bytes
// [R7] any controller range access enters program state
// [R8] byte pointer toggles on address/count access
// [R9] pointer cleared by reset or master clear
// [R10] flip-flop control register sets pointer directly
// [R11] software masks channel before reprogramming
// [R12] active only on unmasked valid request
// [R13] byte transfers: address lines 0-15
// [R14] word transfers: lines 1-16, line 0 zero
// [R15] page bits drive lines 16-23 on byte transfers, page bits 7-1 drive lines 17-23 on word transfers
// [R16] address steps up or down per mode
// [R17] address hold freezes channel zero address
// [R18] count decrements, terminal count at wrap
// [R19] terminal count: mask, or reload address
// [R20] autoinit reloads count from base
// [R21] base address written with current, write-only
// [R22] address port: pointer selects low/high byte
// [R23] count port: pointer selects low/high byte
// [R24] tc flag set; cleared by reset/clear/read
// [R25] software clears pointer, writes low then high
// [R26] every channel keeps its own register set
module dma_channel_address_count #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  input  wire logic [7:0]  dreq,
  input  wire logic [15:0] dev_data,
  output logic      [7:0]  dack,
  output logic      [23:0] dma_addr,
  output logic             active,
  output logic      [1:0]  program_state,
  output logic             terminal_count,
  output logic             mem_valid,
  input  wire logic        mem_ready,
  output logic      [23:0] mem_addr,
  output logic      [15:0] mem_data
);
  localparam int N = dma_channel_pkg::CHANS;

  initial begin
    if (FIFO_DEPTH < 2) $error("fifo depth too small");
  end

  // ==========================================================================
  // io decode
  wire       io_acc   = io_rd | io_wr;
  wire       hit_pri  = io_addr[15:4] == dma_channel_pkg::PRI_IO_BASE; // [R4]
  wire       hit_sec  = io_addr[15:4] == dma_channel_pkg::SEC_IO_BASE; // [R4]
  wire       hit_page = io_addr[15:4] == dma_channel_pkg::PAGE_IO_BASE; // [R5]
  wire [3:0] reg_idx  = io_addr[3:0];
  wire [1:0] ctl_hit  = {hit_sec, hit_pri} & {2{io_acc}};
  wire [2:0] acc_chan = {hit_sec, reg_idx[2:1]};

  logic [1:0] ff_q;
  logic [7:0] cmd_q [2];
  logic [7:0] mask_q;
  logic [7:0] tc_q;
  logic [7:0] tc_set;
  logic [1:0] prog_q;
  logic [15:0] cur_addr_q [N];
  logic [15:0] base_addr_q [N];
  logic [15:0] cur_cnt_q [N];
  logic [15:0] base_cnt_q [N];
  logic [7:0]  page_q [N];
  logic [N-1:0] autoinit_q;
  logic [N-1:0] decr_q;
  dma_channel_pkg::xfer_state_t state_q;
  logic [2:0] sel_q;
  logic       fifo_in_ready;

  wire [1:0] chan_acc   = ctl_hit & {2{~reg_idx[3]}};
  wire [1:0] status_rd  = ctl_hit & {2{io_rd && reg_idx == dma_channel_pkg::REG_STATUS_CMD}};
  wire [1:0] cmd_wr     = ctl_hit & {2{io_wr && reg_idx == dma_channel_pkg::REG_STATUS_CMD}};
  wire [1:0] mask_wr    = ctl_hit & {2{io_wr && reg_idx == dma_channel_pkg::REG_MASK_ONE}};
  wire [1:0] mode_wr    = ctl_hit & {2{io_wr && reg_idx == dma_channel_pkg::REG_MODE}};
  wire [1:0] ffc_wr     = ctl_hit & {2{io_wr && reg_idx == dma_channel_pkg::REG_FF_CTRL}};
  wire [1:0] mclr       = ctl_hit & {2{io_wr && reg_idx == dma_channel_pkg::REG_MASTER_CLR}};
  wire       page_wr    = io_wr && hit_page && !reg_idx[3];
  wire       hold_chan0 = cmd_q[0][dma_channel_pkg::CMD_ADDR_HOLD_BIT];

  // ==========================================================================
  // transfer engine
  wire [7:0] req_ok = dreq & ~mask_q & ~(8'h01 << dma_channel_pkg::CASCADE_CHAN); // [R2] [R3]
  logic [2:0] grant;
  always_comb begin
    grant = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_ok[i]) grant = 3'(i);
    end
  end

  wire start     = (state_q == dma_channel_pkg::XFER_IDLE) && (|req_ok) && !io_acc; // [R12]
  wire xfer_done = (state_q == dma_channel_pkg::XFER_ACTIVE) && fifo_in_ready;
  wire [15:0] g_addr = cur_addr_q[grant];
  wire [7:0]  g_page = page_q[grant];
  wire [23:0] byte_addr = {g_page[7:0], g_addr}; // [R13] [R15]
  wire [23:0] word_addr = {g_page[7:1], g_addr, 1'b0}; // [R14] [R15]
  wire [23:0] grant_addr = grant[2] ? word_addr : byte_addr; // [R1]

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q  <= dma_channel_pkg::XFER_IDLE;
      sel_q    <= 3'h0;
      dack     <= 8'h00;
      dma_addr <= 24'h000000;
      active   <= 1'b0;
    end else if (start) begin
      state_q  <= dma_channel_pkg::XFER_ACTIVE; // [R12]
      sel_q    <= grant;
      dack     <= 8'h01 << grant; // [R3]
      dma_addr <= grant_addr;
      active   <= 1'b1;
    end else if (xfer_done) begin
      state_q <= dma_channel_pkg::XFER_IDLE;
      dack    <= 8'h00;
      active  <= 1'b0;
    end
  end

  // ==========================================================================
  // byte pointer, command, program state, terminal count flags
  for (genvar k = 0; k < 2; k++) begin : g_ctl
    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        ff_q[k]   <= dma_channel_pkg::FF_RESET; // [R9]
        cmd_q[k]  <= dma_channel_pkg::CMD_RESET;
        prog_q[k] <= 1'b0;
      end else begin
        if (mclr[k]) ff_q[k] <= dma_channel_pkg::FF_RESET; // [R9]
        else if (ffc_wr[k]) ff_q[k] <= io_wdata[dma_channel_pkg::FF_CTRL_BIT]; // [R10]
        else if (chan_acc[k]) ff_q[k] <= ~ff_q[k]; // [R8]
        if (mclr[k]) cmd_q[k] <= dma_channel_pkg::CMD_RESET;
        else if (cmd_wr[k]) cmd_q[k] <= io_wdata;
        if (ctl_hit[k]) prog_q[k] <= 1'b1; // [R7]
        else if (start) prog_q[k] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tc_q           <= 8'h00;
      terminal_count <= 1'b0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (tc_set[i]) tc_q[i] <= 1'b1; // [R24]
        else if (mclr[i / 4] || status_rd[i / 4]) tc_q[i] <= 1'b0; // [R24]
      end
      terminal_count <= tc_set != 8'h00;
    end
  end

  assign program_state = prog_q;

  // ==========================================================================
  // per-channel registers
  for (genvar c = 0; c < N; c++) begin : g_chan
    localparam int K = c / 4;
    wire mine     = xfer_done && sel_q == 3'(c);
    wire at_last  = cur_cnt_q[c] == dma_channel_pkg::COUNT_LAST;
    wire reload   = mine && at_last && autoinit_q[c];
    wire wr_addr  = io_wr && chan_acc[K] && acc_chan == 3'(c) && !reg_idx[0];
    wire wr_cnt   = io_wr && chan_acc[K] && acc_chan == 3'(c) && reg_idx[0];
    wire hold     = (c == 0) && hold_chan0;
    wire sel_mask = mask_wr[K] && io_wdata[1:0] == 2'(c % 4);
    wire sel_mode = mode_wr[K] && io_wdata[1:0] == 2'(c % 4);
    wire [15:0] stepped = decr_q[c] ? cur_addr_q[c] - dma_channel_pkg::WORD_STEP
                                    : cur_addr_q[c] + dma_channel_pkg::WORD_STEP; // [R16]
    assign tc_set[c] = mine && at_last; // [R18]

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        cur_addr_q[c]  <= dma_channel_pkg::WORD_RESET;
        base_addr_q[c] <= dma_channel_pkg::WORD_RESET;
        cur_cnt_q[c]   <= dma_channel_pkg::WORD_RESET;
        base_cnt_q[c]  <= dma_channel_pkg::WORD_RESET;
      end else begin
        if (wr_addr && !ff_q[K]) begin
          cur_addr_q[c][7:0]  <= io_wdata; // [R22] [R26]
          base_addr_q[c][7:0] <= io_wdata; // [R21]
        end else if (wr_addr) begin
          cur_addr_q[c][15:8]  <= io_wdata; // [R22] [R6]
          base_addr_q[c][15:8] <= io_wdata; // [R21]
        end else if (reload) begin
          cur_addr_q[c] <= base_addr_q[c]; // [R19]
        end else if (mine && !hold) begin
          cur_addr_q[c] <= stepped; // [R16] [R17]
        end
        if (wr_cnt && !ff_q[K]) begin
          cur_cnt_q[c][7:0]  <= io_wdata; // [R23]
          base_cnt_q[c][7:0] <= io_wdata;
        end else if (wr_cnt) begin
          cur_cnt_q[c][15:8]  <= io_wdata; // [R23] [R6]
          base_cnt_q[c][15:8] <= io_wdata;
        end else if (reload) begin
          cur_cnt_q[c] <= base_cnt_q[c]; // [R20]
        end else if (mine) begin
          cur_cnt_q[c] <= cur_cnt_q[c] - dma_channel_pkg::WORD_STEP; // [R18]
        end
      end
    end

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        mask_q[c]     <= dma_channel_pkg::MASK_RESET[c];
        autoinit_q[c] <= 1'b0;
        decr_q[c]     <= 1'b0;
        page_q[c]     <= dma_channel_pkg::PAGE_RESET;
      end else begin
        if (mclr[K]) mask_q[c] <= 1'b1;
        else if (tc_set[c] && !autoinit_q[c]) mask_q[c] <= 1'b1; // [R19]
        else if (sel_mask) mask_q[c] <= io_wdata[dma_channel_pkg::MASK_SET_BIT];
        if (sel_mode) begin
          autoinit_q[c] <= io_wdata[dma_channel_pkg::MODE_AUTOINIT_BIT];
          decr_q[c]     <= io_wdata[dma_channel_pkg::MODE_DECR_BIT];
        end
        if (page_wr && reg_idx[2:0] == 3'(c)) page_q[c] <= io_wdata; // [R5]
      end
    end
  end

  // ==========================================================================
  // read-back
  wire [15:0] rd_word  = reg_idx[0] ? cur_cnt_q[acc_chan] : cur_addr_q[acc_chan];
  wire        rd_ff    = ff_q[hit_sec];
  wire [7:0]  rd_chan  = rd_ff ? rd_word[15:8] : rd_word[7:0]; // [R22] [R23]
  wire [7:0]  rd_stat  = hit_sec ? {dreq[7:4], tc_q[7:4]} : {dreq[3:0], tc_q[3:0]}; // [R24]
  wire [7:0]  rd_page  = reg_idx[3] ? 8'h00 : page_q[reg_idx[2:0]];
  wire        rd_ctl   = hit_pri || hit_sec;
  wire [7:0]  rd_mux   = hit_page ? rd_page
                       : (rd_ctl && !reg_idx[3]) ? rd_chan
                       : (rd_ctl && reg_idx == dma_channel_pkg::REG_STATUS_CMD) ? rd_stat
                       : 8'h00;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) io_rdata <= 8'h00;
    else if (io_rd) io_rdata <= rd_mux;
  end

  // ==========================================================================
  // data buffer and memory-side output stage
  logic        fifo_out_valid;
  logic [39:0] fifo_out_data;
  wire         out_take = fifo_out_valid && (!mem_valid || mem_ready);

  dma_word_fifo #(
    .WIDTH (40),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (state_q == dma_channel_pkg::XFER_ACTIVE),
    .in_ready  (fifo_in_ready),
    .in_data   ({dma_addr, dev_data}),
    .out_valid (fifo_out_valid),
    .out_ready (!mem_valid || mem_ready),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mem_valid <= 1'b0;
      mem_addr  <= 24'h000000;
      mem_data  <= 16'h0000;
    end else if (out_take) begin
      mem_valid <= 1'b1;
      mem_addr  <= fifo_out_data[39:16];
      mem_data  <= fifo_out_data[15:0];
    end else if (mem_ready) begin
      mem_valid <= 1'b0;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_ff_toggle;
    chan_acc[0] && !mclr[0] && !ffc_wr[0] |=> ff_q[0] != $past(ff_q[0]);
  endproperty
  a_ff_toggle: assert property (p_ff_toggle) else $error("pointer did not toggle"); // [R8]

  property p_mclr;
    mclr[0] |=> !ff_q[0] && mask_q[3:0] == 4'hF;
  endproperty
  a_mclr: assert property (p_mclr) else $error("master clear failed"); // [R9]

  property p_ffc;
    ffc_wr[1] |=> ff_q[1] == $past(io_wdata[0]);
  endproperty
  a_ffc: assert property (p_ffc) else $error("pointer control ignored"); // [R10]

  property p_prog;
    ctl_hit[1] |=> prog_q[1];
  endproperty
  a_prog: assert property (p_prog) else $error("program state not entered"); // [R7]

  property p_cascade;
    !dack[4];
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade channel transferred"); // [R2]

  property p_word_a0;
    active && sel_q[2] |-> !dma_addr[0];
  endproperty
  a_word_a0: assert property (p_word_a0) else $error("word address bit 0 set"); // [R14]

  property p_active_cause;
    $rose(active) |-> $past(req_ok) != 8'h00 && dack == (8'h01 << sel_q);
  endproperty
  a_active_cause: assert property (p_active_cause) else $error("active without request"); // [R12]

  property p_tc_read;
    status_rd[0] && tc_set[3:0] == 4'h0 |=> tc_q[3:0] == 4'h0;
  endproperty
  a_tc_read: assert property (p_tc_read) else $error("tc flags not cleared"); // [R24]

  property p_cnt_dec;
    xfer_done && sel_q == 3'h1 && !io_wr && cur_cnt_q[1] != 16'h0000
      |=> cur_cnt_q[1] == $past(cur_cnt_q[1]) - 16'h0001;
  endproperty
  a_cnt_dec: assert property (p_cnt_dec) else $error("count did not decrement"); // [R18]

  property p_tc_mask;
    tc_set[1] && !autoinit_q[1] && !io_wr |=> mask_q[1] && tc_q[1];
  endproperty
  a_tc_mask: assert property (p_tc_mask) else $error("channel not masked at tc"); // [R19]

  property p_hold;
    xfer_done && sel_q == 3'h0 && hold_chan0 && !io_wr && !tc_set[0]
      |=> cur_addr_q[0] == $past(cur_addr_q[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("held address moved"); // [R17]

  c_word_xfer: cover property (xfer_done && sel_q[2]);
  c_autoinit:  cover property (tc_set[5] && autoinit_q[5]);
  c_fifo_full: cover property (active && !fifo_in_ready);
endmodule : dma_channel_address_count

// ==== isa_periph_model.sv ====
// behavioural isa peripheral: raises requests, supplies data under acknowledge
module isa_periph_model (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [7:0]  dack,
  output logic      [7:0]  dreq,
  output logic      [15:0] dev_data
);
  timeunit 1ns;
  timeprecision 100ps;

  int         left [8];
  logic [7:0] dack_prev;

  // ==========================================================================
  // bench control: ask for n transfers on request line ch
  task automatic request(input int ch, input int n);
    left[ch] = n;
  endtask : request

  initial begin
    dreq      = 8'h00;
    dev_data  = 16'h0000;
    dack_prev = 8'h00;
    foreach (left[i]) left[i] = 0;
  end

  // ==========================================================================
  // one word per acknowledge; data bus toggles when not acknowledged
  always @(posedge clock) begin
    #1;
    for (int i = 0; i < 8; i++) begin
      if (dack[i] && !dack_prev[i] && left[i] > 0) begin
        left[i]--;
        dev_data = {8'(i), 8'(left[i])};
      end
    end
    if (dack == 8'h00) begin
      dev_data = ~dev_data;
    end
    for (int i = 0; i < 8; i++) begin
      dreq[i] = (left[i] > 0) && resetn;
    end
    dack_prev = dack;
  end
endmodule : isa_periph_model

// ==== tb_top.sv ====
// self-checking bench for the dual dma address/count block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int FIFO_DEPTH = 16;

  logic        clock;
  logic        resetn;
  logic        io_rd;
  logic        io_wr;
  logic        mem_ready;
  logic        mem_valid;
  logic        active;
  logic        terminal_count;
  logic [15:0] io_addr;
  logic [15:0] dev_data;
  logic [15:0] mem_data;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic [7:0]  dreq;
  logic [7:0]  dack;
  logic [23:0] dma_addr;
  logic [23:0] mem_addr;
  logic [1:0]  program_state;
  logic [39:0] mq [$];
  logic [15:0] amem [2][4];
  logic [15:0] va;
  logic [15:0] vw;
  logic [15:0] rv;
  logic [7:0]  rd;
  bit          stall;
  int          mismatches;
  int          check_count;
  int          tc_seen;

  dma_channel_address_count #(.FIFO_DEPTH(FIFO_DEPTH)) u_dut (
    .clock(clock), .resetn(resetn), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .dreq(dreq), .dev_data(dev_data),
    .dack(dack), .dma_addr(dma_addr), .active(active), .program_state(program_state),
    .terminal_count(terminal_count), .mem_valid(mem_valid), .mem_ready(mem_ready),
    .mem_addr(mem_addr), .mem_data(mem_data)
  );

  isa_periph_model u_periph (
    .clock(clock), .resetn(resetn), .dack(dack), .dreq(dreq), .dev_data(dev_data)
  );

  always #12.5 clock = ~clock;

  // ==========================================================================
  // memory side sink and event monitors
  always @(posedge clock) begin
    #1;
    mem_ready = stall ? 1'b0 : 1'($urandom % 2);
  end

  always @(posedge clock) begin
    if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
      mq.push_back({mem_addr, mem_data});
    end
    if (terminal_count === 1'b1) begin
      tc_seen++;
    end
  end

  // ==========================================================================
  // comparison, verdict, io cycles
  task automatic chk(input string name, input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  function automatic logic [15:0] ra(input int c, input logic [3:0] idx);
    return {(c != 0) ? dma_channel_pkg::SEC_IO_BASE : dma_channel_pkg::PRI_IO_BASE, idx};
  endfunction : ra

  task automatic io_w(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(posedge clock);
    #1;
    io_wr    = 1'b0;
    io_wdata = ~d;
    io_addr  = ~a;
  endtask : io_w

  task automatic io_r(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    io_addr = a;
    io_rd   = 1'b1;
    @(posedge clock);
    #1;
    io_rd   = 1'b0;
    io_addr = ~a;
    d       = io_rdata;
  endtask : io_r

  task automatic wr16(input int c, input logic [3:0] idx, input logic [15:0] v);
    io_w(ra(c, dma_channel_pkg::REG_FF_CTRL), 8'h00);
    io_w(ra(c, idx), v[7:0]);
    io_w(ra(c, idx), v[15:8]);
  endtask : wr16

  task automatic rd16(input int c, input logic [3:0] idx, output logic [15:0] v);
    io_w(ra(c, dma_channel_pkg::REG_FF_CTRL), 8'h00);
    io_r(ra(c, idx), v[7:0]);
    io_r(ra(c, idx), v[15:8]);
  endtask : rd16

  // ==========================================================================
  // program one channel, run cnt+1 transfers, compare every stored word
  task automatic xfer(input int c, input int ch, input logic [15:0] a, input logic [15:0] cnt,
                      input logic [7:0] pg, input logic [7:0] mode, input bit hold,
                      input bit stall_first);
    int          n;
    int          tc0;
    logic [15:0] cur;
    logic [23:0] ea;
    n     = int'(cnt) + 1;
    tc0   = tc_seen;
    stall = stall_first;
    io_w(ra(c, dma_channel_pkg::REG_MASK_ONE), 8'h04 | 8'(ch));
    io_w(ra(c, dma_channel_pkg::REG_MODE), mode | 8'(ch));
    wr16(c, 4'(2 * ch), a);
    wr16(c, 4'(2 * ch + 1), cnt);
    io_w({dma_channel_pkg::PAGE_IO_BASE, 4'(4 * c + ch)}, pg);
    mq.delete();
    io_w(ra(c, dma_channel_pkg::REG_MASK_ONE), 8'(ch));
    u_periph.request(4 * c + ch, n);
    if (stall_first) begin
      repeat (80) @(posedge clock);
      #2;
      chk("stalled dack", dack, 8'h01 << (4 * c + ch));
      chk("active", active, 1'b1);
      chk("stalled addr", dma_addr, {pg, a + 16'(FIFO_DEPTH + 1)});
      stall = 1'b0;
    end
    for (int k = 0; k < 4000 && mq.size() < n; k++) @(posedge clock);
    repeat (6) @(posedge clock);
    chk("words", mq.size(), n);
    chk("tc pulses", tc_seen - tc0, 1);
    cur = a;
    foreach (mq[i]) begin
      ea = (c == 0) ? {pg, cur} : {pg[7:1], cur, 1'b0};
      chk("mem addr", mq[i][39:16], ea);
      chk("mem data", mq[i][15:0], {8'(4 * c + ch), 8'(n - 1 - i)});
      if (!hold) begin
        cur = mode[dma_channel_pkg::MODE_DECR_BIT] ? cur - 16'h0001 : cur + 16'h0001;
      end
    end
  endtask : xfer

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    clock     = 1'b0;
    resetn    = 1'b0;
    io_rd     = 1'b0;
    io_wr     = 1'b0;
    io_addr   = 16'h0000;
    io_wdata  = 8'h00;
    mem_ready = 1'b0;
    stall     = 1'b1;
    void'($urandom(32'hA42A));
    repeat (10) @(posedge clock);
    #1;
    resetn = 1'b1;
    u_periph.request(2, 1);
    repeat (20) @(posedge clock);
    #2;
    chk("masked dack", dack, 8'h00);
    u_periph.request(2, 0);
    for (int c = 0; c < 2; c++) begin
      for (int ch = 0; ch < 4; ch++) begin
        va = 16'($urandom);
        vw = 16'($urandom);
        amem[c][ch] = va;
        wr16(c, 4'(2 * ch), va);
        wr16(c, 4'(2 * ch + 1), vw);
        rd16(c, 4'(2 * ch), rv);
        chk("address port", rv, va);
        rd16(c, 4'(2 * ch + 1), rv);
        chk("count port", rv, vw);
      end
    end
    chk("program state", program_state[1], 1'b1);
    io_w(ra(0, dma_channel_pkg::REG_FF_CTRL), 8'h01);
    io_r(ra(0, 4'h0), rd);
    chk("pointer set", rd, amem[0][0][15:8]);
    io_r(ra(0, 4'h0), rd);
    chk("pointer toggle", rd, amem[0][0][7:0]);
    io_r(ra(0, 4'h1), rd);
    io_w(ra(0, dma_channel_pkg::REG_FF_CTRL), 8'h01);
    io_w(ra(0, dma_channel_pkg::REG_MASTER_CLR), 8'h00);
    io_r(ra(0, 4'h0), rd);
    chk("pointer clear", rd, amem[0][0][7:0]);
    io_r(16'h0050, rd);
    chk("unmapped", rd, 8'h00);
    io_w(16'h0088, 8'h5A);
    io_r(16'h0088, rd);
    chk("page gap", rd, 8'h00);
    xfer(0, 1, 16'($urandom), 16'd23, 8'($urandom), 8'h00, 1'b0, 1'b1);
    io_r(ra(0, dma_channel_pkg::REG_STATUS_CMD), rd);
    chk("tc status", rd & 8'h0F, 8'h02);
    chk("program state primary", program_state, 2'b01);
    io_r(ra(0, dma_channel_pkg::REG_STATUS_CMD), rd);
    chk("tc status read clear", rd & 8'h0F, 8'h00);
    u_periph.request(1, 1);
    repeat (30) @(posedge clock);
    chk("masked after tc", mq.size(), 24);
    u_periph.request(1, 0);
    io_w(ra(1, dma_channel_pkg::REG_MASK_ONE), 8'h00);
    u_periph.request(4, 1);
    va = 16'($urandom);
    xfer(1, 1, va, 16'd1, 8'($urandom), 8'h30, 1'b0, 1'b0);
    rd16(1, 4'h2, rv);
    chk("autoinit address", rv, va);
    rd16(1, 4'h3, rv);
    chk("autoinit count", rv, 16'h0001);
    u_periph.request(4, 0);
    io_w(ra(0, dma_channel_pkg::REG_STATUS_CMD), 8'h01 << dma_channel_pkg::CMD_ADDR_HOLD_BIT);
    xfer(0, 0, 16'($urandom), 16'd2, 8'($urandom), 8'h00, 1'b1, 1'b0);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    test_done();
  end
endmodule : tb_top
